// ===== core/sss_pkg.sv
package sss_pkg;

  // Clock and documented times, in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SLEEP_RECOVERY_TIME_PS = 20000;

  // Least time rounds up to whole cycles
  localparam int unsigned RECOVERY_CYC_INT =
    (SLEEP_RECOVERY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Clocks from the first edge that sees the request high to sleep
  localparam int unsigned ENTRY_CYC_INT = 2;

  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] RECOVERY_CYC = CNT_W'(RECOVERY_CYC_INT);
  localparam logic [CNT_W-1:0] ENTRY_CYC = CNT_W'(ENTRY_CYC_INT);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // Retained array geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 18;
  localparam int unsigned DEPTH = 16;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;

  typedef enum logic [1:0] {
    SSS_AWAKE = 2'b00,
    SSS_ENTER = 2'b01,
    SSS_SLEEP = 2'b10,
    SSS_RECOVER = 2'b11
  } sss_state_e;

endpackage : sss_pkg

// ===== core/sss_sleep_fsm.sv
`timescale 1ns/10ps
`default_nettype none

module sss_sleep_fsm (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic sleep_request_i,
  output logic asleep_o,
  output logic recovering_o,
  output logic ready_o
);
  import sss_pkg::*;

  sss_state_e state_ff;
  sss_state_e nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  // Count reaches the entry figure at the first edge after the first high one
  wire logic entry_done = (cnt_ff >= ENTRY_CYC);
  wire logic rec_done = (cnt_ff + CNT_ONE) >= RECOVERY_CYC;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      SSS_AWAKE: begin
        if (sleep_request_i) begin
          nxt_state = SSS_ENTER;
          nxt_cnt = CNT_ONE;
        end
      end
      SSS_ENTER: begin
        // Request dropped before sleep: never slept, resume at once
        if (!sleep_request_i) begin
          nxt_state = SSS_AWAKE;
        end else if (entry_done) begin
          nxt_state = SSS_SLEEP;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
      SSS_SLEEP: begin
        if (!sleep_request_i) begin
          nxt_state = SSS_RECOVER;
          nxt_cnt = CNT_ZERO;
        end
      end
      SSS_RECOVER: begin
        if (sleep_request_i) begin
          nxt_state = SSS_ENTER;
          nxt_cnt = CNT_ONE;
        end else if (rec_done) begin
          nxt_state = SSS_AWAKE;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
      default: begin
        nxt_state = SSS_AWAKE;
        nxt_cnt = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_ff <= SSS_AWAKE;
      cnt_ff <= CNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign asleep_o = (state_ff == SSS_SLEEP);
  assign recovering_o = (state_ff == SSS_RECOVER);
  assign ready_o = (state_ff == SSS_AWAKE);

  a_entry_two_clk: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (ready_o && sleep_request_i) ##1 sleep_request_i ##1 sleep_request_i |=> asleep_o)
    else $error("sleep not entered two clocks after request");

  a_sleep_no_timeout: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (asleep_o && sleep_request_i) |=> asleep_o)
    else $error("sleep left while request high");

  a_sleep_exit: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (asleep_o && !sleep_request_i) |=> (recovering_o && !asleep_o))
    else $error("sleep kept after request low");

  a_recovery_min: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(asleep_o) |-> (!ready_o)[*5])
    else $error("resumed before recovery interval");

  a_recovery_max: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ($fell(asleep_o) && !sleep_request_i) ##1 (!sleep_request_i)[*4] |=> ready_o)
    else $error("recovery longer than interval");

endmodule : sss_sleep_fsm
`default_nettype wire

// ===== core/sss_sleep_sram.sv
`timescale 1ns/10ps
`default_nettype none

module sss_sleep_sram (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic sleep_request_i,
  input wire logic select_i,
  input wire logic write_i,
  input wire logic [sss_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sss_pkg::DATA_W-1:0] wdata_i,
  input wire logic out_en_n_i,
  output logic [sss_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic asleep_o,
  output logic recovering_o,
  output logic write_blocked_o
);
  import sss_pkg::*;

  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] data_ff;
  logic [DATA_W-1:0] nxt_data;
  logic drive_ff;
  logic nxt_drive;
  logic ready;
  logic asleep;
  logic recovering;

  sss_sleep_fsm u_fsm (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .sleep_request_i(sleep_request_i),
    .asleep_o(asleep),
    .recovering_o(recovering),
    .ready_o(ready)
  );

  // Commands are ignored entirely while asleep
  wire logic cmd_live = select_i && !asleep;
  // Writes during recovery are dropped, which protects the array
  // against a controller that breaks the recovery protocol
  wire logic wr_go = cmd_live && write_i && !recovering;
  wire logic rd_go = cmd_live && !write_i;
  // Any capture other than a read turns the drivers off next edge
  wire logic deselect = !rd_go;

  always_comb begin
    nxt_data = data_ff;
    nxt_drive = drive_ff;
    if (asleep) begin
      nxt_drive = 1'b0;
    end else if (rd_go) begin
      nxt_data = mem[addr_i];
      nxt_drive = 1'b1;
    end else if (deselect) begin
      // Single cycle deselect: off at the next edge, the same stage at which a read turns on
      nxt_drive = 1'b0;
    end
  end

  // No reset on the array; contents are retained, not initialised
  always_ff @(posedge sys_clk_i) begin
    if (wr_go) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      data_ff <= DATA_RST;
      drive_ff <= 1'b0;
    end else begin
      data_ff <= nxt_data;
      drive_ff <= nxt_drive;
    end
  end

  // Output enable pin acts without the clock
  assign dq_oe_o = drive_ff && !out_en_n_i && !asleep;
  assign dq_o = data_ff;
  assign asleep_o = asleep;
  assign recovering_o = recovering;
  // Entry takes writes, so only sleep and recovery block them
  assign write_blocked_o = asleep || recovering;

  // Separate recovery timer, read only by the checks below,
  // so they do not lean on the state machine's own counter
  logic [CNT_W-1:0] wake_cnt_ff;
  logic [CNT_W-1:0] nxt_wake_cnt;

  always_comb begin
    nxt_wake_cnt = wake_cnt_ff;
    if (asleep) begin
      nxt_wake_cnt = CNT_ZERO;
    end else if (wake_cnt_ff != RECOVERY_CYC) begin
      nxt_wake_cnt = wake_cnt_ff + CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wake_cnt_ff <= RECOVERY_CYC;
    end else begin
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end

  // Sleep entry
  a_entry_not_early: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (ready && sleep_request_i) |=> !asleep ##1 !asleep)
    else $error("sleep entered too early");

  a_entry_abort: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (ready && sleep_request_i) ##1 !sleep_request_i |=> ready)
    else $error("dropped request did not return awake");

  a_entry_write_kept: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (!ready && !asleep && !recovering && select_i && write_i) |-> wr_go)
    else $error("write refused during entry");

  // Sleep
  a_sleep_no_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    asleep |-> !wr_go)
    else $error("array written while asleep");

  a_sleep_data_held: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (asleep && $past(asleep)) |-> $stable(data_ff))
    else $error("output register changed while asleep");

  a_sleep_hiz: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    asleep |-> !dq_oe_o)
    else $error("drivers on while asleep");

  a_sleep_read_ignored: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (asleep && select_i && !write_i) |=> !drive_ff)
    else $error("read taken while asleep");

  a_sleep_blocked: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    asleep |-> write_blocked_o)
    else $error("writes shown open while asleep");

  a_wake_drivers_off: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(asleep) |-> !dq_oe_o)
    else $error("drivers on at wake");

  // Recovery
  a_recover_no_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    recovering |-> !wr_go)
    else $error("write taken during recovery");

  a_recover_blocked: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    recovering |-> write_blocked_o)
    else $error("writes shown open during recovery");

  a_awake_open: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ready |-> !write_blocked_o)
    else $error("writes shown blocked while awake");

  a_wake_timer_full: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ready |-> (wake_cnt_ff == RECOVERY_CYC))
    else $error("awake before recovery time counted out");

  a_wake_timer_low: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    recovering |-> (wake_cnt_ff < RECOVERY_CYC))
    else $error("recovery lasted past its time");

  a_wake_read: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (recovering && select_i && !write_i) |=> drive_ff)
    else $error("read refused during recovery");

  // Data path
  a_read_drives: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    rd_go ##1 (!out_en_n_i && !asleep) |-> dq_oe_o)
    else $error("read did not drive outputs");

  a_deselect_off: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (!select_i && !asleep) |=> !dq_oe_o)
    else $error("drivers on after deselect");

  a_pin_gates_drive: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    out_en_n_i |-> !dq_oe_o)
    else $error("drivers on with output enable pin high");

  a_data_holds: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !rd_go |=> $stable(dq_o))
    else $error("read data changed without a read");

  a_write_read: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_go ##1 (rd_go && addr_i == $past(addr_i)) |=> dq_o == $past(wdata_i, 2))
    else $error("read returned wrong data");

endmodule : sss_sleep_sram
`default_nettype wire

// ===== testbench/sss_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module sss_ctrl_model (
  input wire logic sys_clk_i,
  output logic sleep_request_o,
  output logic select_o,
  output logic write_o,
  output logic [sss_pkg::ADDR_W-1:0] addr_o,
  output logic [sss_pkg::DATA_W-1:0] wdata_o,
  output logic out_en_n_o
);
  import sss_pkg::*;
  bit defy = 1'b0;
  int rcnt = 0;
  initial begin
    sleep_request_o = 1'b0;
    select_o = 1'b0;
    write_o = 1'b0;
    wdata_o = 18'h00000;
    out_en_n_o = 1'b0;
  end
  // Spare cycle, device frees writes one edge late
  always @(posedge sys_clk_i) rcnt <= sleep_request_o ? RECOVERY_CYC_INT + 1 : rcnt - (rcnt > 0);
  // Tasks run one at a time, so nothing pends at a request
  task req(input logic v);
    sleep_request_o = v;
  endtask : req
  task cmd(input logic s, input logic w, input logic [ADDR_W-1:0] a,
           input logic [DATA_W-1:0] d, input logic oen);
    while (s && w && rcnt > 0 && !defy) begin
      @(posedge sys_clk_i);
      #1;
    end
    select_o = s;
    write_o = w;
    addr_o = a;
    wdata_o = (s && w) ? d : ~wdata_o;
    out_en_n_o = oen;
    @(posedge sys_clk_i);
    #1;
  endtask : cmd
endmodule : sss_ctrl_model

`default_nettype wire

// ===== testbench/sss_sleep_sram_tb.sv
`timescale 1ns/10ps
`default_nettype none

module sss_sleep_sram_tb;
  import sss_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  wire sreq, sel, wr, oen, oe, asl, rec, wblk;
  wire [ADDR_W-1:0] addr;
  wire [DATA_W-1:0] wdata, dq;
  int num_errors = 0;
  int cmp_count = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  sss_ctrl_model ctl (.sys_clk_i(sys_clk_i), .sleep_request_o(sreq), .select_o(sel),
    .write_o(wr), .addr_o(addr), .wdata_o(wdata), .out_en_n_o(oen));

  sss_sleep_sram dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sleep_request_i(sreq),
    .select_i(sel), .write_i(wr), .addr_i(addr), .wdata_i(wdata), .out_en_n_i(oen),
    .dq_o(dq), .dq_oe_o(oe), .asleep_o(asl), .recovering_o(rec), .write_blocked_o(wblk));

  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task print_verdict;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task t_rw;
    ctl.cmd(1, 1, 4'h3, 18'h2a5a5, 0);
    ctl.cmd(1, 1, 4'hc, 18'h15a5a, 0);
    ctl.cmd(1, 0, 4'h3, 18'h0, 0);
    chk(dq, 18'h2a5a5);
    chk(DATA_W'(oe), 18'h1);
    chk(DATA_W'(wblk), 18'h0);
    ctl.cmd(1, 0, 4'hc, 18'h0, 1);
    chk(dq, 18'h15a5a);
    chk(DATA_W'(oe), 18'h0);
  endtask : t_rw

  task t_abort;
    ctl.req(1);
    ctl.cmd(0, 0, 4'h0, 18'h0, 0);
    ctl.req(0);
    repeat (4) begin
      ctl.cmd(0, 0, 4'h0, 18'h0, 0);
      chk(DATA_W'({asl, rec}), 18'h0);
    end
  endtask : t_abort

  task t_sleep;
    ctl.defy = 1'b1;
    ctl.req(1);
    repeat (2) begin
      ctl.cmd(1, 0, 4'h3, 18'h0, 0);
      chk(DATA_W'({asl, wblk}), 18'h0);
      chk(DATA_W'(oe), 18'h1);
    end
    ctl.cmd(1, 0, 4'h3, 18'h0, 0);
    chk(DATA_W'(asl), 18'h1);
    chk(DATA_W'(oe), 18'h0);
    repeat (40) begin
      ctl.cmd(1, 1, 4'h3, 18'h3ffff, 0);
      chk(DATA_W'({asl, oe, wblk}), 18'h5);
    end
    ctl.req(0);
    ctl.cmd(1, 1, 4'h3, 18'h3ffff, 0);
    chk(DATA_W'({asl, rec, wblk}), 18'h3);
    ctl.cmd(1, 1, 4'h3, 18'h3ffff, 0);
    repeat (RECOVERY_CYC_INT - 2) ctl.cmd(0, 0, 4'h0, 18'h0, 0);
    chk(DATA_W'(rec), 18'h1);
    ctl.cmd(0, 0, 4'h0, 18'h0, 0);
    chk(DATA_W'(rec), 18'h0);
    ctl.defy = 1'b0;
    ctl.cmd(1, 0, 4'h3, 18'h0, 0);
    chk(dq, 18'h2a5a5);
  endtask : t_sleep

  task t_recov;
    ctl.req(1);
    repeat (3) ctl.cmd(0, 0, 4'h0, 18'h0, 0);
    ctl.req(0);
    ctl.cmd(1, 1, 4'hc, 18'h00777, 0);
    ctl.cmd(1, 0, 4'hc, 18'h0, 0);
    chk(dq, 18'h00777);
  endtask : t_recov

  // Whole run needs under a hundred cycles
  initial begin
    #8000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    ctl.cmd(0, 0, 4'h0, 18'h0, 0);
    t_rw();
    t_abort();
    t_sleep();
    t_recov();
    print_verdict();
  end
endmodule : sss_sleep_sram_tb

`default_nettype wire
